/* rtl/fcsc_defines.vh */
`ifndef FCSC_DEFINES_VH
`define FCSC_DEFINES_VH
// software register byte offsets
`define FCSC_REG_CTRL 4'h0
`define FCSC_REG_ADDR 4'h4
`define FCSC_REG_WDATA 4'h8
`define FCSC_REG_STAT 4'hC
// control word fields
`define FCSC_CTRL_CMD_LSB 0
`define FCSC_CTRL_CMD_MSB 2
`define FCSC_CTRL_BYTE_BIT 4
`define FCSC_CTRL_GO_BIT 8
// host commands
`define FCSC_CMD_RESET 3'h0
`define FCSC_CMD_RESET_UNL 3'h1
`define FCSC_CMD_IDENT 3'h2
`define FCSC_CMD_PROG 3'h3
`define FCSC_CMD_READ 3'h4
`define FCSC_CMD_POLL 3'h5
// flash command codes
`define FCSC_D_UNLOCK1 8'hAA
`define FCSC_D_UNLOCK2 8'h55
`define FCSC_D_RESET 8'hF0
`define FCSC_D_IDENT 8'h90
`define FCSC_D_PROG 8'hA0
// unlock addresses per organisation
`define FCSC_A_UNL1_BYTE 20'h00AAA
`define FCSC_A_UNL2_BYTE 20'h00555
`define FCSC_A_UNL1_WORD 20'h00555
`define FCSC_A_UNL2_WORD 20'h002AA
// status bit positions
`define FCSC_BIT_POLL 7
`define FCSC_BIT_TOG 6
`define FCSC_BIT_ERR 5
`define FCSC_BIT_TIMER 3
`define FCSC_BIT_ETOG 2
// timing
`define FCSC_CLK_MHZ 200
`define FCSC_RESET_WAIT_US 10
`define FCSC_RESET_WAIT_CYC (`FCSC_RESET_WAIT_US * `FCSC_CLK_MHZ)
// strobe phase length in clocks
`define FCSC_PHASE_CYC 20
`endif

/* rtl/fcsc_strobe.v */
`include "fcsc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
// one asynchronous bus cycle: setup, strobe low, hold
module fcsc_strobe #(
    parameter PHASE = `FCSC_PHASE_CYC
) (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire start_in,
    input wire write_in,
    input wire [15:0] dq_in,
    output reg busy_out,
    output reg ce_n_out,
    output reg oe_n_out,
    output reg we_n_out,
    output reg dq_oe_n_out,
    output reg [15:0] rdata_out,
    output reg done_out
);
    reg [1:0] ph_q;
    reg [7:0] cnt_q;
    reg wr_q;
    // phase 1 setup, 2 strobe low, 3 hold
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ph_q <= 2'h0;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            busy_out <= 1'b0;
            ce_n_out <= 1'b1;
            oe_n_out <= 1'b1;
            we_n_out <= 1'b1;
            dq_oe_n_out <= 1'b1;
            rdata_out <= 16'h0000;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (ph_q == 2'h0) begin
                if (start_in) begin
                    ph_q <= 2'h1;
                    cnt_q <= 8'h00;
                    wr_q <= write_in;
                    busy_out <= 1'b1;
                    ce_n_out <= 1'b0;
                    dq_oe_n_out <= ~write_in;
                end
            end else if (cnt_q != PHASE[7:0] - 8'h01) begin
                cnt_q <= cnt_q + 8'h01;
            end else begin
                cnt_q <= 8'h00;
                case (ph_q)
                    2'h1: begin
                        ph_q <= 2'h2;
                        // address latched at this falling strobe edge
                        we_n_out <= ~wr_q;
                        oe_n_out <= wr_q;
                    end
                    2'h2: begin
                        ph_q <= 2'h3;
                        // data latched by the device at the rising edge
                        we_n_out <= 1'b1;
                        oe_n_out <= 1'b1;
                        if (!wr_q)
                            rdata_out <= dq_in;
                    end
                    default: begin
                        ph_q <= 2'h0;
                        ce_n_out <= 1'b1;
                        dq_oe_n_out <= 1'b1;
                        busy_out <= 1'b0;
                        done_out <= 1'b1;
                    end
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* rtl/fcsc_host.v */
// Overview of operation
// - first unlock writes AAh to organisation address
// - second unlock writes 55h to organisation address
// - unlock pair in cycles one/two or four/five
// - wait 10 us after reset from erase
// - identification: unlock pair then 90h
// - program: unlock, A0h, then address/data
//
// The Avalon-MM interface to the registers and the register offsets were left to the implementer.
`include "fcsc_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module fcsc_host #(
    parameter RESET_WAIT = `FCSC_RESET_WAIT_CYC,
    parameter POLL_MAX = 32'h00FFFFFF
) (
    input wire ref_clk_in,
    input wire sys_rst_in,
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    output wire [19:0] flash_addr_out,
    output wire flash_byte_n_out,
    output wire flash_ce_n_out,
    output wire flash_oe_n_out,
    output wire flash_we_n_out,
    input wire [15:0] flash_dq_in,
    output wire [15:0] flash_dq_out,
    output wire flash_dq_oe_n_out
);
    localparam S_IDLE = 3'h0;
    localparam S_ISSUE = 3'h1;
    localparam S_WAIT = 3'h2;
    localparam S_POLL = 3'h3;
    localparam S_HOLD = 3'h4;

    reg [2:0] state_q;
    reg [2:0] cmd_q;
    reg byte_q;
    reg [19:0] addr_q;
    reg [15:0] wdata_q;
    reg [19:0] fa_q;
    reg [15:0] fd_q;
    reg [2:0] step_q;
    reg wr_q;
    reg go_q;
    reg busy_q;
    reg err_q;
    reg timeout_q;
    reg [15:0] rdata_q;
    reg [15:0] prev_q;
    reg prev_ok_q;
    reg [31:0] cnt_q;
    reg erase_mode_q;
    reg [7:0] ack_q;

    wire sb_busy;
    wire sb_done;
    wire [15:0] sb_rdata;
    reg [2:0] nsteps;
    reg [19:0] step_a;
    reg [15:0] step_d;
    reg step_w;
    wire [19:0] a_unl1;
    wire [19:0] a_unl2;
    wire [15:0] diff;

    // organisation picks unlock addresses; upper lines driven zero
    assign a_unl1 = byte_q ? `FCSC_A_UNL1_BYTE : `FCSC_A_UNL1_WORD;
    assign a_unl2 = byte_q ? `FCSC_A_UNL2_BYTE : `FCSC_A_UNL2_WORD;
    assign diff = sb_rdata ^ prev_q;

    // bus sequence per command; unlock always in cycles one and two
    always @* begin
        nsteps = 3'h1;
        step_a = addr_q;
        step_d = 16'h0000;
        step_w = 1'b1;
        case (cmd_q)
            `FCSC_CMD_RESET: begin
                step_d = {8'h00, `FCSC_D_RESET};
            end
            `FCSC_CMD_RESET_UNL, `FCSC_CMD_IDENT, `FCSC_CMD_PROG: begin
                nsteps = (cmd_q == `FCSC_CMD_PROG) ? 3'h4 : 3'h3;
                case (step_q)
                    3'h0: begin
                        step_a = a_unl1;
                        step_d = {8'h00, `FCSC_D_UNLOCK1};
                    end
                    3'h1: begin
                        step_a = a_unl2;
                        step_d = {8'h00, `FCSC_D_UNLOCK2};
                    end
                    3'h2: begin
                        step_a = a_unl1;
                        if (cmd_q == `FCSC_CMD_IDENT)
                            step_d = {8'h00, `FCSC_D_IDENT};
                        else if (cmd_q == `FCSC_CMD_PROG)
                            step_d = {8'h00, `FCSC_D_PROG};
                        else
                            step_d = {8'h00, `FCSC_D_RESET};
                    end
                    default: begin
                        // address and data held across strobe
                        step_a = addr_q;
                        step_d = wdata_q;
                    end
                endcase
            end
            default: begin
                // plain read: array, id codes or protection
                step_w = 1'b0;
            end
        endcase
    end

    fcsc_strobe u_strobe (
        .ref_clk_in(ref_clk_in),
        .sys_rst_in(sys_rst_in),
        .start_in(state_q == S_ISSUE),
        .write_in(step_w), // wr_q only updates at this same edge
        .dq_in(flash_dq_in),
        .busy_out(sb_busy),
        .ce_n_out(flash_ce_n_out),
        .oe_n_out(flash_oe_n_out),
        .we_n_out(flash_we_n_out),
        .dq_oe_n_out(flash_dq_oe_n_out),
        .rdata_out(sb_rdata),
        .done_out(sb_done)
    );

    assign flash_addr_out = fa_q;
    assign flash_dq_out = fd_q;
    assign flash_byte_n_out = ~byte_q;

    // avalon slave: one wait cycle, answer on second cycle
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q[0];

    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            ack_q <= 8'h00;
            avs_readdata_out <= 32'h00000000;
        end else begin
            ack_q <= {7'h00, (avs_read_in | avs_write_in) & ~ack_q[0]};
            if (avs_read_in) begin
                case (avs_address_in)
                    `FCSC_REG_CTRL:
                        avs_readdata_out <= {27'h0, byte_q, 1'b0, cmd_q};
                    `FCSC_REG_ADDR:
                        avs_readdata_out <= {12'h000, addr_q};
                    `FCSC_REG_WDATA:
                        avs_readdata_out <= {16'h0000, wdata_q};
                    `FCSC_REG_STAT:
                        avs_readdata_out <= {busy_q, err_q, timeout_q,
                            erase_mode_q, 12'h000, rdata_q};
                    default:
                        avs_readdata_out <= 32'h00000000;
                endcase
            end
        end
    end

    // command sequencer
    always @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state_q <= S_IDLE;
            cmd_q <= `FCSC_CMD_READ;
            byte_q <= 1'b0;
            addr_q <= 20'h00000;
            wdata_q <= 16'h0000;
            fa_q <= 20'h00000;
            fd_q <= 16'h0000;
            step_q <= 3'h0;
            wr_q <= 1'b0;
            go_q <= 1'b0;
            busy_q <= 1'b0;
            err_q <= 1'b0;
            timeout_q <= 1'b0;
            rdata_q <= 16'h0000;
            prev_q <= 16'h0000;
            prev_ok_q <= 1'b0;
            cnt_q <= 32'h00000000;
            erase_mode_q <= 1'b0;
        end else begin
            go_q <= 1'b0;
            if (avs_write_in && ack_q[0] && !busy_q) begin
                case (avs_address_in)
                    `FCSC_REG_CTRL: begin
                        cmd_q <= avs_writedata_in[`FCSC_CTRL_CMD_MSB:
                            `FCSC_CTRL_CMD_LSB];
                        byte_q <= avs_writedata_in[`FCSC_CTRL_BYTE_BIT];
                        go_q <= avs_writedata_in[`FCSC_CTRL_GO_BIT];
                        // software flags an erase left running elsewhere
                        erase_mode_q <= avs_writedata_in[31];
                    end
                    `FCSC_REG_ADDR: addr_q <= avs_writedata_in[19:0];
                    `FCSC_REG_WDATA: wdata_q <= avs_writedata_in[15:0];
                    default: begin
                    end
                endcase
            end
            case (state_q)
                S_IDLE: begin
                    if (go_q) begin
                        busy_q <= 1'b1;
                        err_q <= 1'b0;
                        timeout_q <= 1'b0;
                        step_q <= 3'h0;
                        prev_ok_q <= 1'b0;
                        state_q <= S_ISSUE;
                    end
                end
                S_ISSUE: begin
                    fa_q <= step_a;
                    fd_q <= step_d;
                    wr_q <= step_w;
                    state_q <= S_WAIT;
                end
                S_WAIT: begin
                    if (sb_done) begin
                        if (!wr_q)
                            rdata_q <= sb_rdata;
                        if (step_q + 3'h1 < nsteps) begin
                            step_q <= step_q + 3'h1;
                            state_q <= S_ISSUE;
                        end else if (cmd_q == `FCSC_CMD_PROG ||
                                cmd_q == `FCSC_CMD_POLL) begin
                            // poll status by toggle bit
                            cmd_q <= `FCSC_CMD_POLL;
                            step_q <= 3'h0;
                            // count polls from the first one only
                            if (cmd_q == `FCSC_CMD_PROG)
                                cnt_q <= 32'h00000000;
                            state_q <= S_ISSUE;
                            if (cmd_q == `FCSC_CMD_POLL)
                                state_q <= S_POLL;
                        end else if ((cmd_q == `FCSC_CMD_RESET ||
                                cmd_q == `FCSC_CMD_RESET_UNL) &&
                                erase_mode_q) begin
                            // array not valid until wait elapses
                            cnt_q <= 32'h00000000;
                            state_q <= S_HOLD;
                        end else begin
                            busy_q <= 1'b0;
                            state_q <= S_IDLE;
                        end
                    end
                end
                S_POLL: begin
                    prev_q <= rdata_q;
                    prev_ok_q <= 1'b1;
                    cnt_q <= cnt_q + 32'h00000001;
                    if (prev_ok_q && !diff[`FCSC_BIT_TOG]) begin
                        // toggling stopped: operation over
                        busy_q <= 1'b0;
                        state_q <= S_IDLE;
                    end else if (prev_ok_q && diff[`FCSC_BIT_TOG] &&
                            prev_q[`FCSC_BIT_ERR] &&
                            rdata_q[`FCSC_BIT_ERR]) begin
                        // two toggling reads with the flag: array data
                        // after completion can carry a stray bit five
                        // error flag seen while busy
                        err_q <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= S_IDLE;
                    end else if (cnt_q == POLL_MAX) begin
                        timeout_q <= 1'b1;
                        busy_q <= 1'b0;
                        state_q <= S_IDLE;
                    end else begin
                        state_q <= S_ISSUE;
                    end
                end
                S_HOLD: begin
                    cnt_q <= cnt_q + 32'h00000001;
                    if (cnt_q == RESET_WAIT - 1) begin
                        erase_mode_q <= 1'b0;
                        busy_q <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* sim/fcsc_host_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// port-level watcher for the flash host
module fcsc_host_sva (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [3:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic [19:0] flash_addr_out,
    input wire logic flash_ce_n_out,
    input wire logic flash_oe_n_out,
    input wire logic flash_we_n_out,
    input wire logic [15:0] flash_dq_out,
    input wire logic flash_dq_oe_n_out
);
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (sys_rst_in);
    // any request on the register bus
    wire req = avs_read_in || avs_write_in;
    // one wait cycle, then the answer
    sequence s_answer;
        avs_waitrequest_out ##1 !avs_waitrequest_out;
    endsequence
    // write strobe held low for at least eight cycles
    sequence s_we_held;
        !flash_we_n_out [*8];
    endsequence
    // chip select settles before either strobe
    sequence s_ce_setup;
        (flash_we_n_out && flash_oe_n_out) [*8];
    endsequence
    chk_answer_one: assert property ($rose(req) |-> s_answer)
        else $error("register answer not after one wait cycle");
    chk_unmapped_zero: assert property (avs_read_in && !avs_waitrequest_out
        && avs_address_in[1:0] != 2'h0 |=> avs_readdata_out == 32'h0)
        else $error("unmapped read did not return zero");
    chk_strobe_excl: assert property (!(!flash_oe_n_out && !flash_we_n_out))
        else $error("read and write strobes low together");
    chk_we_drives: assert property ($fell(flash_we_n_out) |->
        !flash_ce_n_out && !flash_dq_oe_n_out)
        else $error("write strobe without select or data drive");
    chk_we_width: assert property ($fell(flash_we_n_out) |-> s_we_held)
        else $error("write strobe too short");
    chk_write_stable: assert property (!flash_we_n_out &&
        $past(!flash_we_n_out) |-> $stable(flash_addr_out)
        && $stable(flash_dq_out))
        else $error("address or data moved under write strobe");
    chk_read_float: assert property (!flash_oe_n_out |->
        flash_dq_oe_n_out && !flash_ce_n_out)
        else $error("host drives data during a read");
    chk_ce_first: assert property ($fell(flash_ce_n_out) |-> s_ce_setup)
        else $error("strobe fell with chip select");
    chk_idle_reset: assert property ($fell(sys_rst_in) |-> flash_ce_n_out
        && flash_oe_n_out && flash_we_n_out && flash_dq_oe_n_out)
        else $error("flash pins not idle after reset");
endmodule
bind fcsc_host fcsc_host_sva fcsc_host_sva_i (.ref_clk_in, .sys_rst_in,
    .avs_address_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
    .avs_waitrequest_out, .flash_addr_out, .flash_ce_n_out,
    .flash_oe_n_out, .flash_we_n_out, .flash_dq_out, .flash_dq_oe_n_out);
`default_nettype wire

/* sim/fcsc_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
// behavioural flash part, driven by strobe edges only
module fcsc_flash_model #(
    parameter MAKER = 16'h0042,
    parameter PART = 16'h0043,
    parameter BUSY_RD = 3
) (
    input wire logic [19:0] addr_in,
    input wire logic byte_n_in,
    input wire logic ce_n_in,
    input wire logic oe_n_in,
    input wire logic we_n_in,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out
);
    logic [15:0] mem [0:255];
    logic [15:0] rd, pd;
    logic [19:0] wa;
    logic [1:0] cyc;
    logic ident, arm, busy, err, tog;
    int left;
    wire [11:0] a = addr_in[11:0];
    wire [11:0] u1 = byte_n_in ? 12'h555 : 12'hAAA;
    wire [11:0] u2 = byte_n_in ? 12'h2AA : 12'h555;
    wire [7:0] d = dq_in[7:0];
    // erased array, read mode
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
        {cyc, ident, arm, busy, err, tog, rd, pd, wa} = '0;
        left = 0;
    end
    // released bus shows the inverse so a stale copy never passes
    assign dq_out = (!ce_n_in && !oe_n_in) ? rd : ~rd;
    // address taken as the write strobe falls
    always @(negedge we_n_in) if (!ce_n_in) wa = addr_in;
    // data taken as the write strobe rises; busy refuses all writes unless the error flag is set
    always @(posedge we_n_in) begin
        if (!ce_n_in && (!busy || err)) begin
            if (arm) begin
                arm = 0;
                busy = 1;
                left = BUSY_RD;
                pd = dq_in;
                err = |(dq_in & ~mem[wa[7:0]]);
                mem[wa[7:0]] = mem[wa[7:0]] & dq_in;
            end else if (d == 8'hF0) begin
                {cyc, ident, busy, err} = '0;
            end else if (cyc == 0 && a == u1 && d == 8'hAA) begin
                cyc = 1;
            end else if (cyc == 1 && a == u2 && d == 8'h55) begin
                cyc = 2;
            end else if (cyc == 2 && a == u1 && d == 8'h90) begin
                cyc = 0;
                ident = 1;
            end else if (cyc == 2 && a == u1 && d == 8'hA0) begin
                cyc = 0;
                arm = 1;
            end else begin
                {cyc, ident} = '0;
            end
        end
    end
    // each status read flips the toggle bit; a failed program keeps it going
    always @(negedge oe_n_in) begin
        if (!ce_n_in) begin
            if (busy) begin
                tog = ~tog;
                rd = {8'h00, ~pd[7], tog, err, 2'b00, 1'b1, 2'b00};
                left = err ? left : left - 1;
                busy = err || left > 0;
            end else if (ident) begin
                case (addr_in[1:0])
                    2'h0: rd = MAKER;
                    2'h1: rd = PART;
                    2'h2: rd = 16'h0000;
                    default: rd = mem[addr_in[7:0]];
                endcase
            end else begin
                rd = mem[addr_in[7:0]];
            end
        end
    end
endmodule
`default_nettype wire

/* sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fcsc_defines.vh"
// flash host bench: register calls against the flash model
module tb;
    localparam int RWAIT = 20;
    localparam logic [15:0] MAKER = 16'h0042; // arbitrary value
    localparam logic [15:0] PART = 16'h0043; // arbitrary value
    logic ref_clk_in = 0;
    logic sys_rst_in = 1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] q;
    wire [31:0] rdata;
    wire wreq, byte_n, ce_n, oe_n, we_n, dq_oe_n;
    wire [19:0] faddr;
    wire [15:0] host_dq, mdl_dq, flash_dq;
    int miscompares = 0;
    int num_checks = 0;
    int tick = 0;
    int c;
    // 200 MHz clock and a cycle count for timing checks
    initial forever #2.5 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) tick <= tick + 1;
    // wire level from the host's data enable
    assign flash_dq = dq_oe_n ? mdl_dq : host_dq;
    fcsc_host #(.RESET_WAIT(RWAIT), .POLL_MAX(64)) fcsc_host_i (
        .ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
        .avs_address_in(avs_address), .avs_read_in(avs_read),
        .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
        .flash_addr_out(faddr), .flash_byte_n_out(byte_n),
        .flash_ce_n_out(ce_n), .flash_oe_n_out(oe_n), .flash_we_n_out(we_n),
        .flash_dq_in(flash_dq), .flash_dq_out(host_dq),
        .flash_dq_oe_n_out(dq_oe_n));
    fcsc_flash_model #(.MAKER(MAKER), .PART(PART)) fcsc_flash_model_i (
        .addr_in(faddr), .byte_n_in(byte_n), .ce_n_in(ce_n), .oe_n_in(oe_n),
        .we_n_in(we_n), .dq_in(host_dq), .dq_out(mdl_dq));
    task automatic summarize;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one register access, held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk_in);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        // waitrequest and data sampled as they stood at the edge
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (wreq !== 1'b0 && n < 100);
        q = rdata;
        avs_write <= 0;
        avs_read <= 0;
        if (n >= 100) begin
            miscompares++;
            summarize();
        end
    endtask
    // start a command and poll status until not busy
    task automatic run(input logic [31:0] ctrl, output int cyc);
        int n = 0;
        int t0;
        bus(1, `FCSC_REG_CTRL, ctrl | (32'h1 << `FCSC_CTRL_GO_BIT));
        t0 = tick;
        do begin
            bus(0, `FCSC_REG_STAT, 32'h0);
            n++;
        end while (q[31] !== 1'b0 && n < 3000);
        cyc = tick - t0;
        if (n >= 3000) begin
            miscompares++;
            summarize();
        end
    endtask
    // one flash read at an address; result lands in q[15:0]
    task automatic rdf(input logic [19:0] a, input logic bm);
        int k;
        bus(1, `FCSC_REG_ADDR, {12'h0, a});
        run({27'h0, bm, 1'b0, `FCSC_CMD_READ}, k);
    endtask
    // program one word at address 10h
    task automatic prog(input logic [15:0] w);
        int k;
        bus(1, `FCSC_REG_ADDR, 32'h10);
        bus(1, `FCSC_REG_WDATA, {16'h0, w});
        run({29'h0, `FCSC_CMD_PROG}, k);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk_in);
        sys_rst_in <= 0;
        bus(0, `FCSC_REG_STAT, 32'h0);
        cmp("stat busy err", 32'h0, q & 32'hC0000000);
        bus(0, 4'h2, 32'h0);
        cmp("unmapped read", 32'h0, q);
        $display("test reset done");
        run({29'h0, `FCSC_CMD_IDENT}, c);
        for (int i = 0; i < 3; i++) begin
            rdf(i[19:0], 1'b0);
            cmp("id word", i == 0 ? MAKER : i == 1 ? PART : 0, q[15:0]);
        end
        run({29'h0, `FCSC_CMD_RESET}, c);
        rdf(20'h5, 1'b0);
        cmp("array after reset", 32'hFFFF, q[15:0]);
        $display("test ident word done");
        run({27'h0, 1'b1, 1'b0, `FCSC_CMD_IDENT}, c);
        rdf(20'h0, 1'b1);
        cmp("id byte", {24'h0, MAKER[7:0]}, q[7:0]);
        run({27'h0, 1'b1, 1'b0, `FCSC_CMD_RESET_UNL}, c);
        cmp("model left id", 32'h0, fcsc_flash_model_i.ident);
        rdf(20'h0, 1'b1);
        cmp("array byte", 32'hFF, q[7:0]);
        $display("test ident byte done");
        prog(16'h1234);
        cmp("prog err", 32'h0, q[30]);
        rdf(20'h10, 1'b0);
        cmp("prog data", 32'h1234, q[15:0]);
        $display("test program done");
        prog(16'h1235);
        cmp("one over zero", 32'h1, q[30]);
        run(32'h80000000 | `FCSC_CMD_RESET, c);
        // one flash cycle of three phases, then the hold
        cmp("reset wait", 32'h1, {31'h0, c >= 3 * `FCSC_PHASE_CYC + RWAIT});
        cmp("flag cleared", 32'h0, fcsc_flash_model_i.err);
        rdf(20'h10, 1'b0);
        cmp("data kept", 32'h1234, q[15:0]);
        $display("test program error done");
        summarize();
    end
endmodule
`default_nettype wire
